// ==== hdl/isad_pkg.sv ====
// package for the i2c slave address detector
// assumes a 10 MHz system clock and a separate serial clock domain
`default_nettype none
package isad_pkg;
  // ---------------------------------------------------------------
  // constants
  // ---------------------------------------------------------------
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;  // 11110 pattern
  localparam logic [3:0] BIT_COUNT_BYTE = 4'h8;   // bits per byte
  localparam logic       SYNC_RESET_VAL = 1'b1;   // idle bus level

  // control bits from software
  typedef struct packed {
    logic       enable;           // module enable
    logic       ten_bit_mode_sel; // 10-bit addressing
    logic       accept_all_en;    // accept every address
    logic       general_call_en;  // general call enable
    logic       clock_stretch_en; // not read; reads always stretch
    logic [9:0] own_addr_reg;     // own address
    logic [9:0] addr_mask_reg;    // address mask
  } isad_ctrl_t;

  // status bits toward software
  typedef struct packed {
    logic start_seen;           // start flag
    logic stop_seen;            // stop flag
    logic data_not_addr;        // data/address flag
    logic read_dir;             // direction flag
    logic ten_bit_matched_flag; // 10-bit matched
    logic general_call_flag;    // general call seen
    logic rx_full_flag;         // receive buffer full
    logic clock_release_bit;    // 1 releases the clock
  } isad_stat_t;
endpackage : isad_pkg
`default_nettype wire

// ==== hdl/isad_sync.sv ====
// two-flop synchroniser for one level
// assumes the input is asynchronous to i_clk
`default_nettype none
module isad_sync (
  input  wire logic i_clk,  // destination clock
  input  wire logic i_rst,  // synchronous reset, high
  input  wire logic i_d,    // asynchronous level
  output logic      o_q     // synchronised level
);
  import isad_pkg::*;
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic s1; // first stage, read only by s2
    logic s2; // second stage
  } isad_sync_st_t;
  isad_sync_st_t st_reg;  // registered state
  isad_sync_st_t st_next; // next state

  // shift the level through
  always_comb begin
    st_next = '{s1: i_d, s2: st_reg.s1};
    if (i_rst) begin
      st_next = '{s1: SYNC_RESET_VAL, s2: SYNC_RESET_VAL};
    end
  end

  // register stage
  always_ff @(posedge i_clk) begin
    st_reg <= st_next;
  end

  assign o_q = st_reg.s2;
endmodule : isad_sync
`default_nettype wire

// ==== hdl/isad_pulse_xing.sv ====
// toggle crossing that carries a one-cycle event
// assumes source and destination clocks unrelated
`default_nettype none
module isad_pulse_xing (
  input  wire logic i_src_clk, // source clock
  input  wire logic i_src_rst, // source reset, high
  input  wire logic i_pulse,   // source event pulse
  input  wire logic i_dst_clk, // destination clock
  input  wire logic i_dst_rst, // destination reset, high
  output logic      o_pulse    // destination event pulse
);
  import isad_pkg::*;
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic tog_reg;  // source toggle
  logic tog_next; // next toggle
  logic tq;       // synchronised toggle
  logic last_reg; // previous synchronised toggle
  logic last_next;

  // flip on every event
  always_comb begin
    tog_next = i_src_rst ? 1'b0 : (tog_reg ^ i_pulse);
  end

  always_ff @(posedge i_src_clk) begin
    tog_reg <= tog_next;
  end

  isad_sync u_sync (
    .i_clk (i_dst_clk),
    .i_rst (i_dst_rst),
    .i_d   (tog_reg),
    .o_q   (tq)
  );

  // remember the settled toggle
  always_comb begin
    last_next = i_dst_rst ? 1'b0 : tq;
  end

  always_ff @(posedge i_dst_clk) begin
    last_reg <= last_next;
  end

  // edge of the settled toggle is the event
  assign o_pulse = (tq ^ last_reg) & ~i_dst_rst;
endmodule : isad_pulse_xing
`default_nettype wire

// ==== hdl/isad_top.sv ====
// i2c slave address detector: start/stop, address match, stretch
// assumes controls are static during a transfer; the serial clock
// pin also clocks the bit logic, and the pin levels are formed from
// the output enables outside this module
`default_nettype none
module isad_top (
  input  wire logic        i_mclk,        // system clock
  input  wire logic        i_sys_rst,     // sync reset, high
  input  wire logic        i_scl_clk,     // serial clock as link clock
  input  wire logic        i_scl_rst,     // link-domain reset, high
  input  wire isad_pkg::isad_ctrl_t i_ctrl, // control bits
  input  wire logic        i_release_set, // software sets release
  input  wire logic        i_rx_read,     // software read rx buffer
  input  wire logic        i_irq_clear,   // software clears irq flag
  input  wire logic        i_scl_in,      // serial clock pin level
  input  wire logic        i_sda_in,      // serial data pin level
  output logic             o_scl_out,     // clock pin drive value
  output logic             o_scl_oe,      // clock pin enable
  output logic             o_sda_out,     // data pin drive value
  output logic             o_sda_oe,      // data pin enable
  output isad_pkg::isad_stat_t o_stat,    // status flags
  output logic [7:0]       o_rx_data,     // rx buffer contents
  output logic             o_slave_irq_flag // slave interrupt flag
);
  import isad_pkg::*;

  // ---------------------------------------------------------------
  // link domain: bit shifter on serial clock edges
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] shift;  // rx shift register
    logic [3:0] cnt;    // bit count, held at its reset value
  } isad_lnk_t;
  isad_lnk_t lk_reg;  // rising-edge state
  isad_lnk_t lk_next; // next state
  logic      rise_tog_reg;  // toggles per sampled bit
  logic      rise_tog_next;

  // sample each data bit on the rising edge
  always_comb begin
    lk_next.shift = {lk_reg.shift[6:0], i_sda_in};
    lk_next.cnt = lk_reg.cnt;
    rise_tog_next = ~rise_tog_reg;
    if (i_scl_rst) begin
      lk_next = '0;
      rise_tog_next = 1'b0;
    end
  end

  always_ff @(posedge i_scl_clk) begin
    lk_reg <= lk_next;
    rise_tog_reg <= rise_tog_next;
  end

  logic bit_evt;  // one sampled bit, in system domain
  isad_pulse_xing u_bitx (
    .i_src_clk (i_scl_clk),
    .i_src_rst (i_scl_rst),
    .i_pulse   (1'b1),
    .i_dst_clk (i_mclk),
    .i_dst_rst (i_sys_rst),
    .o_pulse   (bit_evt)
  );

  // ---------------------------------------------------------------
  // system domain: synchronised pins
  // ---------------------------------------------------------------
  logic scl_s; // synchronised clock level
  logic sda_s; // synchronised data level
  isad_sync u_scls (
    .i_clk (i_mclk),
    .i_rst (i_sys_rst),
    .i_d   (i_scl_in),
    .o_q   (scl_s)
  );
  isad_sync u_sdas (
    .i_clk (i_mclk),
    .i_rst (i_sys_rst),
    .i_d   (i_sda_in),
    .o_q   (sda_s)
  );

  // ---------------------------------------------------------------
  // system domain state
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001, // waiting for start
    ST_ADDR1 = 6'b000010, // first address byte
    ST_ADDR2 = 6'b000100, // second 10-bit byte
    ST_DATA  = 6'b001000, // addressed, data phase
    ST_IGN   = 6'b010000, // ignoring until stop or start
    ST_ACK   = 6'b100000  // driving ack on ninth bit
  } isad_state_t;

  typedef struct packed {
    isad_state_t state;      // sequencer state
    isad_state_t after_ack;  // state after ack bit
    logic        scl_d;      // previous clock level
    logic        sda_d;      // previous data level
    logic [3:0]  bits;       // bits this byte
    logic [7:0]  sh;         // local copy of shift data
    logic        ten_seen;   // both 10-bit bytes matched
    logic        irq_pend;   // interrupt at ninth fall
    logic        stretch;    // hold clock after ack
    logic        ack_drv;    // driving data low
    logic [7:0]  rx_buf;     // rx buffer
    logic        irq;        // slave interrupt flag
    isad_stat_t  stat;       // status flags
  } isad_sys_t;
  isad_sys_t s_reg;  // registered state
  isad_sys_t s_next; // next state

  // masked equality, 1 where bits agree or are masked
  function automatic logic match_bits(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic [7:0] m);
    match_bits = &((~(a ^ b)) | m);
  endfunction : match_bits

  // reserved 7-bit addresses, never acked by mask
  function automatic logic reserved7(input logic [6:0] a);
    reserved7 = (a[6:3] == 4'h0) || (a[6:3] == 4'hf);
  endfunction : reserved7

  logic       start_det;  // data falls, clock high
  logic       stop_det;   // data rises, clock high
  logic       scl_fall;   // clock falling edge
  logic [7:0] cur_byte;   // byte shifted so far, registered
  logic       m7;         // 7-bit own match
  logic       gc;         // general call byte
  logic       m10a;       // 10-bit first byte
  logic       m10b;       // 10-bit second byte

  // start/stop are data edges with clock high
  assign start_det = s_reg.scl_d & scl_s & s_reg.sda_d & ~sda_s;
  assign stop_det  = s_reg.scl_d & scl_s & ~s_reg.sda_d & sda_s;
  assign scl_fall  = s_reg.scl_d & ~scl_s;
  assign cur_byte  = s_reg.sh;

  // compare terms on the full byte
  assign m7 = match_bits({1'b0, cur_byte[7:1]},
                         {1'b0, i_ctrl.own_addr_reg[6:0]},
                         {1'b0, i_ctrl.addr_mask_reg[6:0]})
              & ~reserved7(cur_byte[7:1]);
  assign gc = (cur_byte == 8'h00) & i_ctrl.general_call_en;
  assign m10a = (cur_byte[7:3] == TEN_BIT_PREFIX)
                & match_bits({6'h00, cur_byte[2:1]},
                             {6'h00, i_ctrl.own_addr_reg[9:8]},
                             {6'h00, i_ctrl.addr_mask_reg[9:8]});
  assign m10b = match_bits(cur_byte, i_ctrl.own_addr_reg[7:0],
                           i_ctrl.addr_mask_reg[7:0]);

  // sequencer, flags and stretch
  always_comb begin
    s_next = s_reg;
    s_next.scl_d = scl_s;
    s_next.sda_d = sda_s;
    if (i_irq_clear) begin
      s_next.irq = 1'b0;
    end
    if (i_rx_read) begin
      s_next.stat.rx_full_flag = 1'b0;
    end
    if (i_release_set) begin
      s_next.stat.clock_release_bit = 1'b1; // release the clock
    end
    // shift a copy of the sampled bit
    if (bit_evt) begin
      s_next.sh = {s_reg.sh[6:0], sda_s};
      s_next.bits = s_reg.bits + 4'h1;
    end
    if (start_det) begin
      s_next.stat.start_seen = 1'b1;
      s_next.stat.stop_seen = 1'b0;
      s_next.bits = 4'h0;
      s_next.ack_drv = 1'b0;
      s_next.state = ST_ADDR1; // wait for start, then address
    end else if (stop_det) begin
      s_next.stat.stop_seen = 1'b1;
      s_next.stat.start_seen = 1'b0;
      s_next.ten_seen = 1'b0;
      s_next.ack_drv = 1'b0;
      s_next.state = ST_IDLE; // ignore ends at stop
    end else if (scl_fall) begin
      case (s_reg.state)
        ST_ADDR1, ST_ADDR2: begin
          if (s_reg.bits == BIT_COUNT_BYTE) begin
            s_next.bits = 4'h0;
            s_next.state = ST_ACK;
            s_next.ack_drv = 1'b1;
            s_next.irq_pend = 1'b1;
            s_next.stat.data_not_addr = 1'b0;
            s_next.stretch = 1'b0;
            if (s_reg.state == ST_ADDR2) begin
              if (m10b) begin
                s_next.stat.ten_bit_matched_flag = 1'b1;
                s_next.ten_seen = 1'b1;
                s_next.after_ack = ST_DATA;
              end else begin
                s_next.ack_drv = 1'b0;
                s_next.irq_pend = 1'b0;
                s_next.state = ST_IGN;
              end
            end else if (i_ctrl.accept_all_en) begin
              s_next.stat.read_dir = cur_byte[0];
              s_next.stretch = cur_byte[0];
              s_next.after_ack = ST_DATA;
            end else if (gc) begin
              // general call, also in 10-bit mode
              s_next.stat.general_call_flag = 1'b1;
              s_next.stat.read_dir = 1'b0;
              s_next.rx_buf = cur_byte;
              s_next.stat.rx_full_flag = 1'b1;
              s_next.after_ack = ST_DATA;
            end else if (i_ctrl.ten_bit_mode_sel && m10a &&
                         (!cur_byte[0] || s_reg.ten_seen)) begin
              s_next.stat.read_dir = cur_byte[0];
              s_next.stretch = cur_byte[0];
              // after repeated start first byte suffices
              s_next.after_ack = s_reg.ten_seen ? ST_DATA : ST_ADDR2;
            end else if (!i_ctrl.ten_bit_mode_sel && m7) begin
              s_next.stat.read_dir = cur_byte[0];
              s_next.stretch = cur_byte[0];
              s_next.after_ack = ST_DATA;
            end else begin
              s_next.ack_drv = 1'b0;
              s_next.irq_pend = 1'b0;
              s_next.state = ST_IGN;
            end
          end
        end
        ST_ACK: begin
          // ninth falling edge: interrupt and stretch
          s_next.ack_drv = 1'b0;
          s_next.bits = 4'h0;
          s_next.state = s_reg.after_ack;
          if (s_reg.irq_pend) begin
            s_next.irq = 1'b1;
            s_next.irq_pend = 1'b0;
          end
          if (s_reg.stretch) begin
            s_next.stat.clock_release_bit = 1'b0;
            s_next.stretch = 1'b0;
          end
        end
        default: begin
          s_next.bits = (s_reg.state == ST_DATA) ? s_reg.bits : 4'h0;
        end
      endcase
    end
    if (i_sys_rst || !i_ctrl.enable) begin
      s_next = '0;
      s_next.state = ST_IDLE;
      s_next.after_ack = ST_IDLE;
      s_next.scl_d = 1'b1;
      s_next.sda_d = 1'b1;
      s_next.stat.clock_release_bit = 1'b1;
    end
  end

  // register all system state
  always_ff @(posedge i_mclk) begin
    s_reg <= s_next;
  end

  // ---------------------------------------------------------------
  // outputs: open-drain style, drive low only
  // ---------------------------------------------------------------
  assign o_scl_out = 1'b0;
  assign o_scl_oe = ~s_reg.stat.clock_release_bit; // hold low
  assign o_sda_out = 1'b0;
  assign o_sda_oe = s_reg.ack_drv;
  assign o_stat = s_reg.stat;
  assign o_rx_data = s_reg.rx_buf;
  assign o_slave_irq_flag = s_reg.irq;
endmodule : isad_top
`default_nettype wire

// ==== verif/isad_monitor.sv ====
// checker on the detector ports, system clock domain
// assumes it is bound onto isad_top by the bench
`default_nettype none
module isad_monitor (
  input wire logic                 i_mclk,          // system clock
  input wire logic                 i_sys_rst,       // reset, high
  input wire isad_pkg::isad_ctrl_t i_ctrl,          // controls
  input wire logic                 i_release_set,   // release pulse
  input wire logic                 i_scl_in,        // clock line
  input wire logic                 i_sda_in,        // data line
  input wire logic                 o_scl_oe,        // clock hold
  input wire logic                 o_sda_oe,        // ack drive
  input wire isad_pkg::isad_stat_t o_stat,          // flags
  input wire logic [7:0]           o_rx_data,       // rx buffer
  input wire logic                 o_slave_irq_flag // irq flag
);
  import isad_pkg::*;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  // ------------------------------
  // bus conditions and ack steps
  // ------------------------------
  sequence s_start_pin;
    $fell(i_sda_in) && i_scl_in && i_ctrl.enable;
  endsequence
  sequence s_stop_pin;
    $rose(i_sda_in) && i_scl_in && i_ctrl.enable;
  endsequence
  sequence s_ack_held;
    o_sda_oe [*8];
  endsequence
  // ------------------------------
  // properties
  // ------------------------------
  property p_dis_clr;
    !i_ctrl.enable [*2] |-> !o_stat.start_seen && !o_stat.stop_seen;
  endproperty
  a_dis_clr: assert property (p_dis_clr) else $error("flags kept");
  property p_start;
    s_start_pin |-> ##[1:6] (o_stat.start_seen && !o_stat.stop_seen);
  endproperty
  a_start: assert property (p_start) else $error("start missed");
  property p_stop;
    s_stop_pin |-> ##[1:6] (o_stat.stop_seen && !o_stat.start_seen);
  endproperty
  a_stop: assert property (p_stop) else $error("stop missed");
  property p_irq;
    $rose(o_slave_irq_flag) |-> !i_scl_in && !o_stat.data_not_addr;
  endproperty
  a_irq: assert property (p_irq) else $error("irq timing");
  property p_ack_edge;
    $rose(o_sda_oe) || $fell(o_sda_oe) |-> !i_scl_in;
  endproperty
  a_ack_edge: assert property (p_ack_edge) else $error("ack edge");
  property p_ack_len;
    $rose(o_sda_oe) |-> s_ack_held;
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("ack short");
  property p_stretch;
    $fell(o_stat.clock_release_bit) |-> o_stat.read_dir ##[0:2] o_scl_oe;
  endproperty
  a_stretch: assert property (p_stretch) else $error("no hold");
  property p_hold;
    o_scl_oe && !o_stat.clock_release_bit && !i_release_set |=> o_scl_oe;
  endproperty
  a_hold: assert property (p_hold) else $error("hold lost");
  property p_release;
    i_release_set |-> ##[1:3] !o_scl_oe;
  endproperty
  a_release: assert property (p_release) else $error("no release");
  property p_gc;
    $rose(o_stat.general_call_flag)
      |-> ##[0:3] (o_stat.rx_full_flag && o_rx_data == 8'h00);
  endproperty
  a_gc: assert property (p_gc) else $error("gc buffer");
endmodule : isad_monitor
`default_nettype wire

// ==== verif/isad_master.sv ====
// bus master model: start, stop, bytes with ack sampling
// assumes open-drain lines with pull-ups formed by the bench
`default_nettype none
module isad_master (
  input  wire logic i_mclk, // paces the bus
  input  wire logic i_scl,  // clock line level
  input  wire logic i_sda,  // data line level
  output logic      o_scl,  // 0 pulls clock low
  output logic      o_sda,  // 0 pulls data low
  output logic      o_hang  // clock held too long
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
    o_hang = 1'b0;
  end
  task automatic q;
    repeat (3) @(posedge i_mclk);
  endtask : q
  // release clock, honour stretching with a bound
  task automatic rise;
    int n;
    o_scl <= 1'b1;
    n = 0;
    while (i_scl !== 1'b1 && n < 400) begin
      @(posedge i_mclk);
      n++;
    end
    if (n == 400) o_hang <= 1'b1;
    q;
  endtask : rise
  // scl edges while the detector is held in reset
  task automatic tick;
    repeat (3) begin
      @(posedge i_mclk);
      o_scl <= 1'b0;
      @(posedge i_mclk);
      o_scl <= 1'b1;
    end
  endtask : tick
  // data changes while the clock is low, except the start and stop edges
  task automatic start;
    q; o_sda <= 1'b1; q; rise; o_sda <= 1'b0; q; o_scl <= 1'b0;
  endtask : start
  task automatic stop;
    q; o_sda <= 1'b0; q; rise; o_sda <= 1'b1; q;
  endtask : stop
  task automatic bit_io(input logic b, output logic s);
    q; o_sda <= b; q; rise; s = i_sda; o_scl <= 1'b0;
  endtask : bit_io
  // msb first, then a released ninth bit for the ack
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask : send_byte
endmodule : isad_master
`default_nettype wire

// ==== verif/tb.sv ====
// bench for the address detector with a bus master model
// assumes isad_top, isad_master and isad_monitor compiled first
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import isad_pkg::*;
  logic       i_mclk = 1'b0;    // system clock
  logic       i_sys_rst = 1'b1; // reset
  isad_ctrl_t ctrl = '0;        // controls
  logic       rel = 1'b0;       // release pulse
  logic       rxr = 1'b0;       // buffer read pulse
  logic       irqc = 1'b0;      // irq clear pulse
  logic       mscl, msda, hang, scl_oe, scl_o, sda_oe, sda_o, irq;
  isad_stat_t stat;             // flags
  logic [7:0] rxd;              // rx buffer
  int         bad_count = 0;    // mismatches
  int         tests_run = 0;    // comparisons
  logic [7:0] rsv [7] = '{8'h00, 8'h04, 8'h08, 8'h0a, 8'h06, 8'hf8, 8'hf4};
  wire logic  scl_w = mscl & ~(scl_oe & ~scl_o); // pulled-up clock
  wire logic  sda_w = msda & ~(sda_oe & ~sda_o); // pulled-up data
  always #50 i_mclk = ~i_mclk;
  isad_master i_mst (.i_mclk(i_mclk), .i_scl(scl_w), .i_sda(sda_w),
    .o_scl(mscl), .o_sda(msda), .o_hang(hang));
  isad_top i_dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .i_scl_clk(scl_w), .i_scl_rst(i_sys_rst), .i_ctrl(ctrl),
    .i_release_set(rel), .i_rx_read(rxr), .i_irq_clear(irqc),
    .i_scl_in(scl_w), .i_sda_in(sda_w), .o_scl_out(scl_o),
    .o_scl_oe(scl_oe), .o_sda_out(sda_o), .o_sda_oe(sda_oe),
    .o_stat(stat), .o_rx_data(rxd), .o_slave_irq_flag(irq));
  // ------------------------------
  // tasks
  // ------------------------------
  task automatic test_done;
    if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic cmp(input string n, input logic [7:0] e, s);
    tests_run++;
    if (s !== e) begin
      $display("BAD %s expected %h seen %h", n, e, s);
      bad_count++;
    end
  endtask : cmp
  task automatic wt(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : wt
  // controls always enabled, stretch off
  task automatic cfg(input logic ten, gc, all, input logic [9:0] a, m);
    @(posedge i_mclk);
    ctrl <= isad_ctrl_t'({1'b1, ten, all, gc, 1'b0, a, m});
    wt(3);
  endtask : cfg
  task automatic byt(input logic [7:0] b, input logic e);
    logic a;
    i_mst.send_byte(b, a);
    cmp("ack", 8'(e), 8'(a));
  endtask : byt
  // flags after a matched address
  task automatic post(input logic d);
    wt(6);
    cmp("irq", 8'h1, 8'(irq));
    cmp("dir", 8'(d), 8'(stat.read_dir));
    cmp("dna", 8'h0, 8'(stat.data_not_addr));
  endtask : post
  task automatic clr;
    @(posedge i_mclk);
    {irqc, rxr} <= 2'b11;
    @(posedge i_mclk);
    {irqc, rxr} <= 2'b00;
    wt(3);
    cmp("irq", 8'h0, 8'(irq));
    cmp("full", 8'h0, 8'(stat.rx_full_flag));
  endtask : clr
  // software answer to a held read
  task automatic relp;
    wt(20);
    cmp("hold", 8'h1, 8'(scl_oe));
    @(posedge i_mclk);
    rel <= 1'b1;
    @(posedge i_mclk);
    rel <= 1'b0;
    wt(4);
    cmp("hold", 8'h0, 8'(scl_oe));
  endtask : relp
  // ------------------------------
  // watchdogs
  // ------------------------------
  always @(posedge i_mclk) begin
    if (hang) begin
      bad_count++;
      test_done;
    end
  end
  initial begin
    wt(30000);
    bad_count++;
    test_done;
  end
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    i_mst.tick;
    wt(2);
    i_sys_rst <= 1'b0;
    cfg(0, 0, 0, 10'h02a, 10'h000);
    i_mst.start;
    wt(6);
    cmp("start", 8'h1, 8'(stat.start_seen));
    byt(8'h54, 1'b1);
    post(1'b0);
    i_mst.stop;
    wt(6);
    cmp("stop", 8'h1, 8'(stat.stop_seen));
    cmp("start", 8'h0, 8'(stat.start_seen));
    clr;
    ctrl.enable <= 1'b0;
    wt(3);
    cmp("stop", 8'h0, 8'(stat.stop_seen));
    cfg(0, 0, 0, 10'h02a, 10'h000);
    i_mst.start;
    byt(8'h55, 1'b1);
    post(1'b1);
    cmp("rel", 8'h0, 8'(stat.clock_release_bit));
    relp;
    i_mst.stop;
    clr;
    i_mst.start;
    byt(8'h56, 1'b0);
    byt(8'h54, 1'b0);
    i_mst.stop;
    cmp("irq", 8'h0, 8'(irq));
    cfg(0, 0, 0, 10'h02a, 10'h001);
    i_mst.start;
    byt(8'h56, 1'b1);
    i_mst.stop;
    clr;
    for (int m = 0; m < 2; m++) begin
      cfg(0, 0, m[0], 10'h002, 10'h07f);
      foreach (rsv[i]) begin
        i_mst.start;
        byt(rsv[i], m[0]);
        i_mst.stop;
      end
      clr;
    end
    cfg(1, 1, 0, 10'h2a5, 10'h000);
    i_mst.start;
    byt(8'h00, 1'b1);
    wt(6);
    cmp("gc", 8'h1, 8'(stat.general_call_flag));
    cmp("full", 8'h1, 8'(stat.rx_full_flag));
    cmp("rxd", 8'h00, rxd);
    i_mst.stop;
    clr;
    i_mst.start;
    byt(8'hf4, 1'b1);
    post(1'b0);
    byt(8'ha5, 1'b1);
    wt(6);
    cmp("ten", 8'h1, 8'(stat.ten_bit_matched_flag));
    clr;
    i_mst.start;
    byt(8'hf5, 1'b1);
    post(1'b1);
    relp;
    i_mst.stop;
    clr;
    i_mst.start;
    byt(8'hf6, 1'b0);
    i_mst.stop;
    cfg(1, 0, 0, 10'h2a5, 10'h300);
    i_mst.start;
    byt(8'hf2, 1'b1);
    byt(8'ha5, 1'b1);
    i_mst.stop;
    clr;
    test_done;
  end
endmodule : tb
bind isad_top isad_monitor i_mon (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
  .i_ctrl(i_ctrl), .i_release_set(i_release_set), .i_scl_in(i_scl_in),
  .i_sda_in(i_sda_in), .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe),
  .o_stat(o_stat), .o_rx_data(o_rx_data),
  .o_slave_irq_flag(o_slave_irq_flag));
`default_nettype wire
